// [verilog/mmc_pkg.sv]
// mmc_pkg: register map, field layout, codes and timing of mode control.
// assumes a 250 MHz system clock and a serial host link on its own clock.
package mmc_pkg;

  // ----------------------------------------------------------------------
  // register offsets on the serial host link
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODEM_CFG = 8'ha1;
  localparam logic [7:0] ADDR_OUT_GAIN = 8'hb0;
  localparam logic [7:0] ADDR_IN_ROUTE = 8'hb1;
  localparam logic [7:0] ADDR_TX_BLOCK_BUFFER = 8'hb5;
  localparam logic [7:0] ADDR_TXLAST = 8'hb6;
  localparam logic [7:0] ADDR_MODE = 8'hc1;
  localparam logic [7:0] ADDR_ANA_CTRL = 8'hc3;
  localparam logic [7:0] ADDR_STATUS = 8'hc6;
  localparam logic [7:0] ADDR_PROG = 8'hc8;
  localparam logic [7:0] ADDR_MASK = 8'hce;

  // ----------------------------------------------------------------------
  // operating_mode_select layout and codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam int DIR_LSB = 0;
  localparam int SUB_LSB = 4;
  localparam int ANA_LSB = 8;
  localparam logic [3:0] DIR_IDLE = 4'h0;
  localparam logic [3:0] DIR_RX = 4'h1;
  localparam logic [3:0] DIR_TX = 4'h2;
  localparam logic [3:0] DIR_RX_CAL = 4'h5;
  localparam logic [3:0] DIR_RX_PS = 4'h9;
  localparam logic [3:0] SUB_IDLE = 4'h0;
  localparam logic [3:0] SUB_FMT = 4'h1;
  localparam logic [3:0] SUB_RAW = 4'h2;
  localparam logic [3:0] SUB_EYE = 4'h3;
  localparam logic [3:0] SUB_PRBS = 4'h3;
  localparam logic [3:0] SUB_PASS = 4'h4;
  localparam logic [3:0] SUB_PRE = 4'h4;
  localparam logic [3:0] SUB_MODSET = 4'h5;
  localparam logic [3:0] SUB_SYNC = 4'h6;
  localparam logic [3:0] SUB_TEST = 4'h6;
  localparam logic [3:0] SUB_ABORT = 4'h7;
  // analogue enables, relative to ANA_LSB; bit 4 is reserved
  localparam logic [7:0] ANA_VALID = 8'hef;

  // ----------------------------------------------------------------------
  // other fields
  // ----------------------------------------------------------------------
  localparam int ST_PROG = 0;
  localparam int ST_DRDY = 1;
  localparam int ST_TXDONE = 2;
  localparam int ST_IRQ = 15;
  localparam int CFG_IQ = 0;
  localparam int CFG_VOC_DIS = 1;
  localparam int RT_OUT_SWAP = 2;
  localparam logic [1:0] IN_ALT = 2'h0;
  localparam logic [1:0] IN_DEMOD = 2'h1;
  localparam logic [1:0] IN_MIC = 2'h2;
  localparam int HDR_VOICE = 15;

  // ----------------------------------------------------------------------
  // symbols, framing, pseudo-random generator, timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] SYM_P3 = 2'h1;
  localparam logic [1:0] SYM_M3 = 2'h3;
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam int PRBS_LEN = 9;
  localparam int PRBS_TAP = 5;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int SYM_PERIOD_NS = 416667;
  localparam int SYM_CYCLES = SYM_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int STRAP_CATCH = 2;

  typedef enum logic [5:0] {
    TS_IDLE = 6'h01,
    TS_PRE = 6'h02,
    TS_SYNC = 6'h04,
    TS_PAY = 6'h08,
    TS_DRAIN = 6'h10,
    TS_DONE = 6'h20
  } mmc_tx_state_t;

endpackage

// [verilog/mmc_sync.sv]
// mmc_sync: two flip-flop level synchroniser, one per bit.
// assumes each bit is an independent level from another domain.
module mmc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // mmc_sync

// [verilog/mmc_prbs.sv]
// mmc_prbs: nine-stage pseudo-random generator, 511-bit period.
// assumes the caller steps it once per output bit.
module mmc_prbs
  import mmc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control
  input wire logic restart_i,
  input wire logic step_i,
  output logic bit_o
);
  logic [PRBS_LEN-1:0] lfsr_q;

  // x^9 + x^5 + 1
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lfsr_q <= PRBS_SEED;
    end else if (restart_i) begin
      lfsr_q <= PRBS_SEED;
    end else if (step_i) begin
      lfsr_q <= {lfsr_q[PRBS_LEN-2:0],
                 lfsr_q[PRBS_LEN-1] ^ lfsr_q[PRBS_TAP-1]};
    end
  end

  assign bit_o = lfsr_q[PRBS_LEN-1];
endmodule // mmc_prbs

// [verilog/mmc_modem_mode_control.sv]
// mmc_modem_mode_control: mode word, strobe pins, transmit sequencing.
// assumes a serial host link clocked by the host, idle-high select.
// Summary of operation
// - reset leaves the device idle; idle still permits monitoring
// - programming word accepted only while idle; host idles first
// - mode bits 3..0 choose idle, rx, tx, rx cal, rx powersave
// - strobe pins follow mode bits 0 and 1 in idle, rx, tx and rx cal, polarity set by straps
// - mode bits 7..4 choose sub-mode per direction; 0111 aborts
// - mode bits 15..8 enable analogue modes, bit 12 reserved
// - formatted transmit: host loads header, device sends preamble, sync
// - data-ready raised once the header word leaves the data buffer
// - voice headers with vocoder enabled take payload from vocoder
// - transmit-done raised only after the last symbol leaves modulator
// - prbs transmit: preamble, sync, then repeating 511-bit sequence
// - preamble transmit repeats +3 +3 -3 -3 until mode changes
// - first input routed from alternate, demodulator or voice pickup
// - two internal outputs routable to either modulator pin
// - formatted speech reroutes mic and speaker to vocoder unless disabled
// - separate gains per input and output plus fine attenuation word
// - analogue control writes forward mic and speaker gain to vocoder
// - interrupt pin low while summary flag and its mask are set
// - status read clears all flags but programming flag, and summary
module mmc_modem_mode_control
  import mmc_pkg::*;
#(
  parameter int SYM_CYC = SYM_CYCLES,
  parameter int PRE_SYMS = 48,
  parameter int SYNC_SYMS = 24,
  parameter logic [47:0] SYNC_PATTERN = 48'h5a5a_a5a5_5a5a,
  parameter int MOD_LAT_SYMS = 4
) (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // serial host link
  input wire logic link_sclk_i,
  input wire logic link_csn_i,
  input wire logic link_cdata_i,
  output logic link_rdata_o,
  output logic link_rdata_oe_o,
  // strobe pins and straps
  input wire logic [1:0] polarity_strap_pins_i,
  output logic strobe_pin_a_o,
  output logic strobe_pin_b_o,
  output logic interrupt_request_low_o,
  // decoded mode
  output logic [3:0] direction_o,
  output logic [3:0] sub_mode_o,
  output logic [7:0] analogue_en_o,
  // routing and gains
  output logic [1:0] input1_sel_o,
  output logic outputs_swapped_o,
  output logic [15:0] out_gain_o,
  output logic [15:0] in_route_o,
  output logic [15:0] fine_atten_o,
  output logic fine_atten_stb_o,
  output logic vocoder_route_o,
  input wire logic rx_speech_i,
  // vocoder
  output logic [15:0] voc_gain_o,
  output logic voc_gain_stb_o,
  input wire logic [15:0] voc_data_i,
  input wire logic voc_last_i,
  input wire logic voc_valid_i,
  output logic voc_ready_o,
  // symbols towards the modulator
  output logic [1:0] tx_symbol_o,
  output logic tx_symbol_stb_o
);
  localparam int SYM_W = $clog2(SYM_CYC);

  // ----------------------------------------------------------------------
  // link domain: shift in command and data, shift out status
  // ----------------------------------------------------------------------
  logic frame_rst_n;
  logic [4:0] bit_cnt_q;
  logic [22:0] sh_q;
  logic [7:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic wr_tog_q, rd_tog_q;
  logic [15:0] rd_sh_q;
  logic rd_oe_q;
  logic [15:0] status_q, status_lk;

  // the select line ends each frame; a stopped link clock needs no edge
  assign frame_rst_n = resetn_i & ~link_csn_i;

  mmc_sync #(.WIDTH(16)) u_status_sync (
    .clk_i(link_sclk_i),
    .rst_n_i(resetn_i),
    .d_i(status_q),
    .q_o(status_lk)
  );

  always_ff @(posedge link_sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 5'h00;
      sh_q <= 23'h000000;
    end else begin
      sh_q <= {sh_q[21:0], link_cdata_i};
      if (bit_cnt_q != 5'(FRAME_BITS)) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // words stay held after the frame so the system side can pick them up
  always_ff @(posedge link_sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_addr_q <= 8'h00;
      wr_data_q <= 16'h0000;
      wr_tog_q <= 1'b0;
      rd_tog_q <= 1'b0;
    end else begin
      if (bit_cnt_q == 5'(FRAME_BITS - 1)) begin
        wr_addr_q <= sh_q[22:15];
        wr_data_q <= {sh_q[14:0], link_cdata_i};
        wr_tog_q <= ~wr_tog_q;
      end
      if (bit_cnt_q == 5'(CMD_BITS - 1) &&
          {sh_q[6:0], link_cdata_i} == ADDR_STATUS) begin
        rd_tog_q <= ~rd_tog_q;
      end
    end
  end

  always_ff @(posedge link_sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_sh_q <= 16'h0000;
      rd_oe_q <= 1'b0;
    end else if (bit_cnt_q == 5'(CMD_BITS - 1)) begin
      rd_sh_q <= status_lk;
      rd_oe_q <= ({sh_q[6:0], link_cdata_i} == ADDR_STATUS);
    end else begin
      rd_sh_q <= {rd_sh_q[14:0], 1'b0};
      if (bit_cnt_q == 5'(FRAME_BITS - 1)) begin
        rd_oe_q <= 1'b0;
      end
    end
  end

  assign link_rdata_o = rd_sh_q[15];
  assign link_rdata_oe_o = rd_oe_q;

  // ----------------------------------------------------------------------
  // crossing of write and read events into the system domain
  // ----------------------------------------------------------------------
  logic [1:0] tog_s, strap_s;
  logic wr_seen_q, rd_seen_q, wr_ev, rd_clr;

  mmc_sync #(.WIDTH(2)) u_tog_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(resetn_i),
    .d_i({rd_tog_q, wr_tog_q}),
    .q_o(tog_s)
  );

  mmc_sync #(.WIDTH(2)) u_strap_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(resetn_i),
    .d_i(polarity_strap_pins_i),
    .q_o(strap_s)
  );

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_seen_q <= 1'b0;
      rd_seen_q <= 1'b0;
    end else begin
      wr_seen_q <= tog_s[0];
      rd_seen_q <= tog_s[1];
    end
  end

  assign wr_ev = tog_s[0] ^ wr_seen_q;
  assign rd_clr = tog_s[1] ^ rd_seen_q;

  // ----------------------------------------------------------------------
  // host registers
  // ----------------------------------------------------------------------
  logic [15:0] mode_q, cfg_q, mask_q, buf_q;
  logic buf_full_q, buf_last_q, buf_take;
  logic [3:0] dir, sub;

  assign dir = mode_q[DIR_LSB +: 4];
  assign sub = mode_q[SUB_LSB +: 4];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= MODE_RESET;
      cfg_q <= 16'h0000;
      mask_q <= 16'h0000;
      out_gain_o <= 16'h0000;
      in_route_o <= 16'h0000;
      voc_gain_o <= 16'h0000;
      fine_atten_o <= 16'h0000;
    end else if (wr_ev) begin
      case (wr_addr_q)
        ADDR_MODE: mode_q <= wr_data_q;
        ADDR_MODEM_CFG: cfg_q <= wr_data_q;
        ADDR_MASK: mask_q <= wr_data_q;
        ADDR_OUT_GAIN: out_gain_o <= wr_data_q;
        ADDR_IN_ROUTE: in_route_o <= wr_data_q;
        ADDR_ANA_CTRL: voc_gain_o <= wr_data_q;
        ADDR_PROG: begin
          if (dir == DIR_IDLE) begin
            fine_atten_o <= wr_data_q;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      voc_gain_stb_o <= 1'b0;
      fine_atten_stb_o <= 1'b0;
    end else begin
      voc_gain_stb_o <= wr_ev && wr_addr_q == ADDR_ANA_CTRL;
      fine_atten_stb_o <= wr_ev && wr_addr_q == ADDR_PROG &&
                          dir == DIR_IDLE;
    end
  end

  // one-word transmit buffer; a later write overwrites an unsent word
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_q <= 16'h0000;
      buf_full_q <= 1'b0;
      buf_last_q <= 1'b0;
    end else if (wr_ev && (wr_addr_q == ADDR_TX_BLOCK_BUFFER ||
                           wr_addr_q == ADDR_TXLAST)) begin
      buf_q <= wr_data_q;
      buf_full_q <= 1'b1;
      buf_last_q <= (wr_addr_q == ADDR_TXLAST);
    end else if (buf_take) begin
      buf_full_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // decoded mode, analogue enables, routing
  // ----------------------------------------------------------------------
  assign direction_o = dir;
  assign sub_mode_o = (sub[3] || sub == SUB_ABORT) ? SUB_IDLE : sub;
  assign analogue_en_o = mode_q[ANA_LSB +: 8] & ANA_VALID;
  assign input1_sel_o = (in_route_o[1:0] == IN_MIC) ? IN_MIC :
                        (in_route_o[1:0] == IN_DEMOD) ? IN_DEMOD :
                        IN_ALT;
  assign outputs_swapped_o = in_route_o[RT_OUT_SWAP];

  // ----------------------------------------------------------------------
  // strobe pins: polarity straps caught once after reset release
  // ----------------------------------------------------------------------
  logic [1:0] strap_cnt_q, strap_q;
  logic rx_act, tx_act;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_cnt_q <= 2'h0;
      strap_q <= 2'h0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'(STRAP_CATCH)) begin
        strap_q <= strap_s;
      end
    end
  end

  // reserved direction codes leave both strobes inactive
  assign rx_act = dir == DIR_RX || dir == DIR_RX_CAL;
  assign tx_act = dir == DIR_TX;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_pin_a_o <= 1'b0;
      strobe_pin_b_o <= 1'b0;
    end else if (dir == DIR_RX_PS) begin
      strobe_pin_a_o <= 1'b0;
      strobe_pin_b_o <= 1'b1;
    end else begin
      strobe_pin_a_o <= rx_act ^ strap_q[0];
      strobe_pin_b_o <= tx_act ^ strap_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------------
  mmc_tx_state_t st_q;
  logic [SYM_W-1:0] sym_cnt_q;
  logic [7:0] idx_q;
  logic tick, tx_run, fmt, prbs_mode, prbs_bit, hdr_q, voice_q;
  logic [3:0] run_sub_q;
  logic [15:0] sh_tx_q;
  logic [3:0] dib_left_q;
  logic last_q;
  logic [1:0] dib_q;
  logic voc_ok, drdy_ev, done_ev;

  assign tx_run = dir == DIR_TX && (sub == SUB_FMT || sub == SUB_PRBS ||
                  sub == SUB_PRE);
  assign fmt = run_sub_q == SUB_FMT;
  assign prbs_mode = run_sub_q == SUB_PRBS;
  assign tick = sym_cnt_q == SYM_W'(SYM_CYC - 1);
  assign voc_ok = voice_q && !cfg_q[CFG_VOC_DIS] && voc_valid_i;
  assign buf_take = st_q == TS_PAY && fmt && tick && dib_left_q == 4'h0 &&
                    !voc_ok && buf_full_q;
  assign voc_ready_o = st_q == TS_PAY && fmt && tick &&
                       dib_left_q == 4'h0 && voc_ok;
  assign drdy_ev = buf_take;
  assign done_ev = st_q == TS_DRAIN && tick &&
                   idx_q == 8'(MOD_LAT_SYMS - 1);

  mmc_prbs u_prbs (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .restart_i(st_q != TS_PAY),
    .step_i(st_q == TS_PAY && prbs_mode &&
            sym_cnt_q < SYM_W'(2)),
    .bit_o(prbs_bit)
  );

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sym_cnt_q <= '0;
      dib_q <= 2'h0;
    end else begin
      sym_cnt_q <= (st_q == TS_IDLE || tick) ? '0 : sym_cnt_q + 1'b1;
      if (sym_cnt_q < SYM_W'(2)) begin
        dib_q <= {dib_q[0], prbs_bit};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= TS_IDLE;
      idx_q <= 8'h00;
      run_sub_q <= SUB_IDLE;
      sh_tx_q <= 16'h0000;
      dib_left_q <= 4'h0;
      last_q <= 1'b0;
      hdr_q <= 1'b0;
      voice_q <= 1'b0;
      tx_symbol_o <= 2'h0;
      tx_symbol_stb_o <= 1'b0;
    end else begin
      tx_symbol_stb_o <= 1'b0;
      if (!tx_run || (st_q != TS_IDLE && sub != run_sub_q)) begin
        st_q <= TS_IDLE; // abort or mode change ends the burst
      end else begin
        case (st_q)
          TS_IDLE: begin
            st_q <= TS_PRE;
            idx_q <= 8'h00;
            run_sub_q <= sub;
            hdr_q <= 1'b1;
            voice_q <= 1'b0;
            dib_left_q <= 4'h0;
          end
          TS_PRE: if (tick) begin
            tx_symbol_stb_o <= 1'b1;
            tx_symbol_o <= idx_q[1] ? SYM_M3 : SYM_P3;
            idx_q <= idx_q + 8'h01;
            if (run_sub_q != SUB_PRE &&
                idx_q == 8'(PRE_SYMS - 1)) begin
              st_q <= TS_SYNC;
              idx_q <= 8'h00;
            end
          end
          TS_SYNC: if (tick) begin
            tx_symbol_stb_o <= 1'b1;
            tx_symbol_o <= SYNC_PATTERN[2 * (SYNC_SYMS - 1 - idx_q) +: 2];
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'(SYNC_SYMS - 1)) begin
              st_q <= TS_PAY;
              idx_q <= 8'h00;
            end
          end
          TS_PAY: if (tick) begin
            if (prbs_mode) begin
              tx_symbol_stb_o <= 1'b1;
              tx_symbol_o <= dib_q;
            end else if (dib_left_q != 4'h0) begin
              tx_symbol_stb_o <= 1'b1;
              tx_symbol_o <= sh_tx_q[15:14];
              sh_tx_q <= {sh_tx_q[13:0], 2'h0};
              dib_left_q <= dib_left_q - 4'h1;
              if (dib_left_q == 4'h1 && last_q) begin
                st_q <= TS_DRAIN;
              end
            end else if (voc_ok || buf_full_q) begin
              tx_symbol_stb_o <= 1'b1;
              tx_symbol_o <= voc_ok ? voc_data_i[15:14] : buf_q[15:14];
              sh_tx_q <= voc_ok ? {voc_data_i[13:0], 2'h0} :
                                  {buf_q[13:0], 2'h0};
              dib_left_q <= 4'h7;
              last_q <= voc_ok ? voc_last_i : buf_last_q;
              hdr_q <= 1'b0;
              if (hdr_q) begin
                voice_q <= buf_q[HDR_VOICE];
              end
            end else begin
              st_q <= TS_DRAIN; // underrun ends the burst
            end
          end
          TS_DRAIN: if (tick) begin
            idx_q <= idx_q + 8'h01;
            if (done_ev) begin
              st_q <= TS_DONE;
            end
          end
          TS_DONE: ;
          default: st_q <= TS_IDLE;
        endcase
      end
    end
  end

  // speech payload in formatted modes moves mic and speaker to vocoder
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vocoder_route_o <= 1'b0;
    end else begin
      vocoder_route_o <= sub == SUB_FMT && !cfg_q[CFG_VOC_DIS] &&
        ((dir == DIR_TX && voice_q) ||
         (rx_act && rx_speech_i));
    end
  end

  // ----------------------------------------------------------------------
  // event flags, summary flag and interrupt pin
  // ----------------------------------------------------------------------
  logic drdy_q, done_q, irq_q;
  logic [2:0] flags, flags_prev_q, mask_prev_q;
  logic irq_set;

  assign flags = {done_q, drdy_q, dir == DIR_IDLE};
  assign irq_set = |(flags & ~flags_prev_q & mask_q[2:0]) ||
                   |(flags & mask_q[2:0] & ~mask_prev_q);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drdy_q <= 1'b0;
      done_q <= 1'b0;
      irq_q <= 1'b0;
      flags_prev_q <= 3'h0;
      mask_prev_q <= 3'h0;
      status_q <= 16'h0000;
      interrupt_request_low_o <= 1'b1;
    end else begin
      // a new event wins over a clearing read in the same cycle
      drdy_q <= drdy_ev | (drdy_q & ~rd_clr);
      done_q <= done_ev | (done_q & ~rd_clr);
      irq_q <= irq_set | (irq_q & ~rd_clr);
      flags_prev_q <= flags;
      mask_prev_q <= mask_q[2:0];
      status_q <= {irq_q, 12'h000, flags};
      interrupt_request_low_o <= ~(irq_q & mask_q[ST_IRQ]);
    end
  end
endmodule // mmc_modem_mode_control

// [tb/mmc_host_model.sv]
// mmc_host_model: host end of the serial link, one frame per call.
// assumes status bits come back on rdata while oe is high.
module mmc_host_model (
  // link pins
  output logic sclk_o,
  output logic csn_o,
  output logic cdata_o,
  input wire logic rdata_i,
  input wire logic rdata_oe_i
);
  timeunit 1ns / 1ps;
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    cdata_o = 1'b0;
  end
  // clock stands still between frames; whole word in one frame
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] r);
    logic [23:0] w;
    w = {a, d};
    r = 16'h0000;
    csn_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      cdata_o = w[i];
      #62.5;
      if (i < 16)
        r[i] = rdata_oe_i ? rdata_i : 1'bx;
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
    end
    #62.5;
    csn_o = 1'b1;
    // released data line must not look like a held value
    cdata_o = ~cdata_o;
  endtask
endmodule // mmc_host_model

// [tb/mmc_assertions.sv]
// mmc_assertions: port checks of mode decode, strobe pins and symbols.
// assumes the straps hold still while out of reset.
module mmc_assertions
  import mmc_pkg::*;
(
  // watched ports
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] polarity_strap_pins_i,
  input wire logic strobe_pin_a_o,
  input wire logic strobe_pin_b_o,
  input wire logic [3:0] direction_o,
  input wire logic [3:0] sub_mode_o,
  input wire logic [7:0] analogue_en_o,
  input wire logic fine_atten_stb_o,
  input wire logic tx_symbol_stb_o
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic [2:0] up_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  reset_idle_a: assert property ($rose(resetn_i) |->
    direction_o == DIR_IDLE && sub_mode_o == SUB_IDLE)
    else $error("not idle after reset");
  strobe_a_a: assert property (up_q == 3'h7 && $stable(direction_o) &&
    direction_o inside {4'h0, 4'h1, 4'h2, 4'h5} |=> strobe_pin_a_o ==
    ($past(direction_o[0]) ^ polarity_strap_pins_i[0])) else $error("pin a");
  strobe_b_a: assert property (up_q == 3'h7 && $stable(direction_o) &&
    direction_o inside {4'h0, 4'h1, 4'h2, 4'h5} |=> strobe_pin_b_o ==
    ($past(direction_o[1]) ^ polarity_strap_pins_i[1])) else $error("pin b");
  ps_strobe_a: assert property (up_q == 3'h7 && $stable(direction_o) &&
    direction_o == DIR_RX_PS |=> !strobe_pin_a_o && strobe_pin_b_o)
    else $error("powersave pins");
  prog_idle_a: assert property (fine_atten_stb_o |->
    direction_o == DIR_IDLE) else $error("program word outside idle");
  sub_code_a: assert property (!sub_mode_o[3] &&
    sub_mode_o != SUB_ABORT) else $error("reserved sub-mode shown");
  ana_rsvd_a: assert property (analogue_en_o[4] == 1'b0)
    else $error("reserved analogue bit");
  sym_tx_a: assert property (tx_symbol_stb_o |->
    direction_o == DIR_TX || $past(direction_o) == DIR_TX)
    else $error("symbol outside tx");
endmodule // mmc_assertions

bind mmc_modem_mode_control mmc_assertions mmc_assertions_inst (.sys_clk_i,
  .resetn_i, .polarity_strap_pins_i, .strobe_pin_a_o, .strobe_pin_b_o,
  .direction_o, .sub_mode_o, .analogue_en_o, .fine_atten_stb_o,
  .tx_symbol_stb_o);

// [tb/modem_mode_control_test.sv]
// modem_mode_control_test: link-level tests of mode control.
// assumes the host model drives the link; symbols last 8 clocks.
module modem_mode_control_test;
  timeunit 1ns / 1ps;
  import mmc_pkg::*;
  localparam logic [47:0] SP = 48'h5a5aa5a55a5a;
  logic sys_clk_i, resetn_i, link_sclk_i, link_csn_i, link_cdata_i;
  logic link_rdata_o, link_rdata_oe_o, strobe_pin_a_o, strobe_pin_b_o;
  logic interrupt_request_low_o, outputs_swapped_o, fine_atten_stb_o;
  logic vocoder_route_o, rx_speech_i, voc_gain_stb_o, voc_last_i;
  logic voc_valid_i, voc_ready_o, tx_symbol_stb_o;
  logic [1:0] polarity_strap_pins_i, input1_sel_o, tx_symbol_o;
  logic [3:0] direction_o, sub_mode_o;
  logic [7:0] analogue_en_o;
  logic [15:0] out_gain_o, in_route_o, fine_atten_o, voc_gain_o, voc_data_i;
  logic [15:0] st;
  logic [1:0] syms[$];
  logic [15:0] m[5] = '{16'h0001, 16'h0009, 16'h0002, 16'hff71, 16'h0081};
  logic [1:0] p[5] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
  int fail_count = 0, checked = 0, cyc = 0;
  mmc_modem_mode_control #(.SYM_CYC(8), .PRE_SYMS(8), .SYNC_PATTERN(SP))
    mmc_modem_mode_control_inst (.sys_clk_i, .resetn_i, .link_sclk_i,
    .link_csn_i, .link_cdata_i, .link_rdata_o, .link_rdata_oe_o,
    .polarity_strap_pins_i, .strobe_pin_a_o, .strobe_pin_b_o,
    .interrupt_request_low_o, .direction_o, .sub_mode_o, .analogue_en_o,
    .input1_sel_o, .outputs_swapped_o, .out_gain_o, .in_route_o,
    .fine_atten_o, .fine_atten_stb_o, .vocoder_route_o, .rx_speech_i,
    .voc_gain_o, .voc_gain_stb_o, .voc_data_i, .voc_last_i, .voc_valid_i,
    .voc_ready_o, .tx_symbol_o, .tx_symbol_stb_o);
  mmc_host_model mmc_host_model_inst (.sclk_o(link_sclk_i),
    .csn_o(link_csn_i), .cdata_o(link_cdata_i), .rdata_i(link_rdata_o),
    .rdata_oe_i(link_rdata_oe_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    mmc_host_model_inst.xfer(a, d, st);
    repeat (8) @(negedge sys_clk_i);
  endtask
  task automatic report_and_stop();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge sys_clk_i) begin
    if (tx_symbol_stb_o === 1'b1)
      syms.push_back(tx_symbol_o);
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    logic [15:0] e;
    resetn_i = 1'b0;
    polarity_strap_pins_i = 2'b01;
    rx_speech_i = 1'b0;
    voc_data_i = 16'hc000;
    voc_last_i = 1'b1;
    voc_valid_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    chk(16'({direction_o, strobe_pin_b_o, strobe_pin_a_o}), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_MODE, m[i]);
      e = {m[i][15:8] & ANA_VALID,
           ((m[i][7] || m[i][6:4] == 3'h7) ? 4'h0 : m[i][7:4]), m[i][3:0]};
      chk({analogue_en_o, sub_mode_o, direction_o}, e);
      chk(16'({strobe_pin_b_o, strobe_pin_a_o}), 16'(p[i]));
    end
    wr(ADDR_PROG, 16'h1234);
    chk(fine_atten_o, 16'h0000);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_PROG, 16'h1234);
    chk(fine_atten_o, 16'h1234);
    wr(ADDR_OUT_GAIN, 16'h00a5);
    wr(ADDR_IN_ROUTE, 16'h0006);
    wr(ADDR_ANA_CTRL, 16'h5a3c);
    wr(8'h00, 16'hffff);
    chk(out_gain_o, 16'h00a5);
    chk(16'({outputs_swapped_o, input1_sel_o}), 16'h0006);
    chk(voc_gain_o, 16'h5a3c);
    // formatted burst of one non-voice header word
    wr(ADDR_MASK, 16'h8006);
    wr(ADDR_STATUS, 16'h0000);
    wr(ADDR_TXLAST, 16'h0000);
    syms.delete();
    wr(ADDR_MODE, 16'h0012);
    repeat (500) @(negedge sys_clk_i);
    chk(16'(syms.size()), 16'h0028);
    for (int k = 0; k < 40; k++) begin
      e = k < 32 ? 16'(SP[63 - 2 * k -: 2]) : 16'h0000;
      if (k < 8)
        e = (k % 4) < 2 ? 16'(SYM_P3) : 16'(SYM_M3);
      chk(16'(syms[k]), e);
    end
    chk(16'(interrupt_request_low_o), 16'h0000);
    wr(ADDR_STATUS, 16'h0000);
    chk(st, 16'h8006);
    chk(16'(interrupt_request_low_o), 16'h0001);
    wr(ADDR_STATUS, 16'h0000);
    chk(st, 16'h0000);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_TX_BLOCK_BUFFER, 16'h8000);
    syms.delete();
    wr(ADDR_MODE, 16'h0012);
    repeat (500) @(negedge sys_clk_i);
    chk(16'({vocoder_route_o, syms[32], syms[40]}), 16'h001b);
    chk(16'(syms.size()), 16'h0030);
    syms.delete();
    wr(ADDR_MODE, 16'h0042);
    repeat (200) @(negedge sys_clk_i);
    for (int k = 0; k < 24; k++)
      chk(16'(syms[k]), (k % 4) < 2 ? 16'h0001 : 16'h0003);
    wr(ADDR_MODE, 16'h0000);
    syms.delete();
    wr(ADDR_MODE, 16'h0032);
    repeat (300) @(negedge sys_clk_i);
    for (int k = 32; k < 37; k++)
      chk(16'(syms[k]), k < 36 ? 16'h0003 : 16'h0002);
    report_and_stop();
  end
endmodule // modem_mode_control_test
